// ---- verilog/lotc_pkg.sv ----
/*
  Package for the LVDS output termination and control pin block.
  It holds the serial frame layout, the register address and field positions,
  reset values and the decode of the parallel control pins.
  It assumes a 10 MHz core clock and a serial port clock well below a quarter of it.
*/
package lotc_pkg;

  // Serial frame: five address bits, then eleven data bits, first bit is the address MSB.
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned DATA_W     = 11;
  localparam int unsigned FRAME_LEN  = ADDR_W + DATA_W;
  localparam int unsigned BITCNT_W   = 4;
  localparam logic [BITCNT_W-1:0] LAST_BIT = 4'hF;

  // Register addresses.
  localparam logic [ADDR_W-1:0] TERM_WORD_ADDR  = 5'h11;
  localparam logic [ADDR_W-1:0] SOFT_RESET_ADDR = 5'h00;
  localparam int unsigned       SOFT_RESET_BIT  = 1;

  // Field layout of data_termination_word_mode.
  localparam int unsigned TERM_LSB   = 0;
  localparam int unsigned TERM_W     = 5;
  localparam int unsigned WMODE_LSB  = 9;
  localparam int unsigned WMODE_W    = 2;
  localparam logic [TERM_W-1:0]  TERM_RESET  = 5'h00;
  localparam logic [WMODE_W-1:0] WMODE_RESET = 2'h0;

  // Word-mode field codes.
  localparam logic [WMODE_W-1:0] WMODE_BYTE_BIT = 2'h0;
  localparam logic [WMODE_W-1:0] WMODE_WORD     = 2'h3;

  // Parallel decode of the serial clock and data pins, clock pin as MSB.
  localparam logic [1:0] PAR_NORMAL     = 2'h0;
  localparam logic [1:0] PAR_DESKEW     = 2'h1;
  localparam logic [1:0] PAR_SYNC       = 2'h2;
  localparam logic [1:0] PAR_POWER_DOWN = 2'h3;

  // Synchroniser depth for pin inputs.
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [0:0] {
    LOTC_IDLE  = 1'b0,
    LOTC_SHIFT = 1'b1
  } lotc_state_t;

endpackage

// ---- verilog/lotc_sync.sv ----
/*
  Multi-bit level synchroniser, one chain of flip-flops per bit.
  It assumes each bit is an independent slow level from outside the clock domain.
*/
`timescale 1ns/1ps
module lotc_sync #(
  parameter int unsigned WIDTH  = 4,
  parameter int unsigned STAGES = 2
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (WIDTH < 1 || STAGES < 2) begin : g_bad_params
    $error("lotc_sync needs at least one bit and two stages");
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic [STAGES-1:0] chain;
      always_ff @(posedge core_clk) begin
        if (srst) begin
          chain <= '0;
        end else begin
          chain <= {chain[STAGES-2:0], async_in[gi]};
        end
      end
      assign sync_out[gi] = chain[STAGES-1];
    end
  endgenerate

endmodule

// ---- verilog/lotc_top.sv ----
/*
  Serial programming port, the output termination and word-mode register, and the
  parallel role of the three control pins of a quad ADC serial LVDS output.
  It assumes the pins are asynchronous to core_clk and that the serial clock runs
  slower than a quarter of core_clk, so each of its edges is seen after sync.
*/
// Summary of operation
// - Hardware or software reset clears the termination and word-mode register to zero.
// - Termination bits 4..0 select none, 166, 200, 250, 333 or 500 ohm.
// - Several termination bits set enable all selected resistors in parallel.
// - Word-mode bits 10..9 act only with the two-wire interface selected.
// - Word-mode 00 gives byte-wise or bit-wise output and 1x frame clock.
// - Word-mode 11 gives word-wise output and half-rate frame clock; 01, 10 unused.
// - With reset pin low, serial clock pin clocks the programming port.
// - With reset pin low, serial data pin carries address and data.
// - With reset pin low, serial enable pin frames each register write.
// - With reset pin high, clock and data pins select deskew, sync, power-down.
// - With reset pin high, enable pin selects coarse gain and reference mode.
// - In two-wire mode a format bit selects byte-wise or bit-wise output.
`timescale 1ns/1ps
module lotc_top
  import lotc_pkg::*;
(
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  input  wire logic                        reset_pin,
  input  wire logic                        serial_clk_pin,
  input  wire logic                        serial_port_data_pin,
  input  wire logic                        serial_port_enable_pin,
  input  wire logic                        two_wire_select,
  input  wire logic                        bit_wise_select,
  output logic      [lotc_pkg::TERM_W-1:0] data_term_enable,
  output logic      [lotc_pkg::WMODE_W-1:0] word_mode_field,
  output logic                             word_wise_active,
  output logic                             frame_clk_half_rate,
  output logic                             byte_wise_active,
  output logic                             bit_wise_active,
  output logic                             serial_mode_active,
  output logic                             parallel_deskew,
  output logic                             parallel_sync,
  output logic                             parallel_power_down,
  output logic                             parallel_gain_ref_sel,
  output logic                             soft_reset_pulse
);

  import lotc_pkg::*;

  // The bit counter must wrap exactly at the frame end, and both fields must fit the data word.
  if (FRAME_LEN != (1 << BITCNT_W) || LAST_BIT != FRAME_LEN - 1) begin : g_bad_frame
    $error("lotc_top frame length does not match its bit counter");
  end
  if (TERM_LSB + TERM_W > DATA_W || WMODE_LSB + WMODE_W > DATA_W) begin : g_bad_fields
    $error("lotc_top register fields do not fit the data word");
  end
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("lotc_top needs at least two synchroniser stages");
  end

  // Synchronised pins.
  logic [3:0] pins_async;
  logic [3:0] pins_sync;
  logic       reset_pin_s;
  logic       sclk_s;
  logic       serial_port_data_pin_s;
  logic       sen_s;

  // The enable pin idles high, so it travels inverted and a cleared chain reads as idle after srst.
  assign pins_async = {reset_pin, serial_clk_pin, serial_port_data_pin, ~serial_port_enable_pin};

  lotc_sync #(
    .WIDTH  (4),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  assign reset_pin_s = pins_sync[3];
  assign sclk_s      = pins_sync[2];
  assign serial_port_data_pin_s     = pins_sync[1];
  assign sen_s       = ~pins_sync[0];

  // Serial port state.
  lotc_state_t             state;
  lotc_state_t             next_state;
  logic                    sclk_d;
  logic [FRAME_LEN-1:0]    shift;
  logic [FRAME_LEN-1:0]    next_shift;
  logic [BITCNT_W-1:0]     bit_cnt;
  logic [BITCNT_W-1:0]     next_bit_cnt;
  logic [TERM_W-1:0]       term_q;
  logic [WMODE_W-1:0]      wmode_q;

  // Decode of the serial port.
  wire serial_mode   = ~reset_pin_s;
  wire port_enabled  = serial_mode & ~sen_s;
  wire sclk_rise     = port_enabled & sclk_s & ~sclk_d;
  wire frame_done    = (state == LOTC_SHIFT) & sclk_rise & (bit_cnt == LAST_BIT);
  wire [FRAME_LEN-1:0] frame_word = {shift[FRAME_LEN-2:0], serial_port_data_pin_s};
  wire [ADDR_W-1:0]    frame_addr = frame_word[FRAME_LEN-1:DATA_W];
  wire [DATA_W-1:0]    frame_data = frame_word[DATA_W-1:0];
  wire write_term    = frame_done & (frame_addr == TERM_WORD_ADDR);
  wire write_soft    = frame_done & (frame_addr == SOFT_RESET_ADDR) & frame_data[SOFT_RESET_BIT];
  // A high reset pin also clears, so parallel mode keeps the register at zero.
  wire clear_reg     = srst | reset_pin_s | write_soft;

  always_comb begin
    next_state   = state;
    next_shift   = shift;
    next_bit_cnt = bit_cnt;
    unique case (state)
      LOTC_IDLE: begin
        next_bit_cnt = '0;
        if (port_enabled) begin
          next_state = LOTC_SHIFT;
          if (sclk_rise) begin
            next_shift   = frame_word;
            next_bit_cnt = 4'h1;
          end
        end
      end
      LOTC_SHIFT: begin
        if (!port_enabled) begin
          // An enable released mid-frame discards the partial frame.
          next_state   = LOTC_IDLE;
          next_bit_cnt = '0;
        end else if (sclk_rise) begin
          next_shift   = frame_word;
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == LAST_BIT) begin
            next_state = LOTC_IDLE;
          end
        end
      end
    endcase
  end

  // Serial port registers.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= LOTC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      shift <= '0;
    end else begin
      shift <= next_shift;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bit_cnt <= '0;
    end else begin
      bit_cnt <= next_bit_cnt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  // The register; bits 8..5 are not stored and read as zero.
  always_ff @(posedge core_clk) begin
    if (clear_reg) begin
      term_q <= TERM_RESET;
    end else if (write_term) begin
      term_q <= frame_data[TERM_LSB +: TERM_W];
    end
  end

  always_ff @(posedge core_clk) begin
    if (clear_reg) begin
      wmode_q <= WMODE_RESET;
    end else if (write_term) begin
      wmode_q <= frame_data[WMODE_LSB +: WMODE_W];
    end
  end

  // Output mode decode; reserved word-mode codes behave as code 00.
  wire word_sel       = two_wire_select & (wmode_q == WMODE_WORD);
  wire next_word_wise = word_sel;
  wire next_half_rate = word_sel;
  wire next_bit_wise  = two_wire_select & ~word_sel & bit_wise_select;
  wire next_byte_wise = two_wire_select & ~word_sel & ~bit_wise_select;

  // Parallel pin decode, valid only while the reset pin is high.
  wire [1:0] par_code = {sclk_s, serial_port_data_pin_s};
  wire next_deskew    = reset_pin_s & (par_code == PAR_DESKEW);
  wire next_sync      = reset_pin_s & (par_code == PAR_SYNC);
  wire next_pdown     = reset_pin_s & (par_code == PAR_POWER_DOWN);
  wire next_gain_ref  = reset_pin_s & sen_s;

  // Output flops, one short block each, all cleared by srst.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_term_enable <= TERM_RESET;
    end else begin
      // Each set bit enables its own resistor, so combinations add in parallel.
      data_term_enable <= term_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      word_mode_field <= WMODE_RESET;
    end else begin
      word_mode_field <= wmode_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      word_wise_active <= 1'b0;
    end else begin
      word_wise_active <= next_word_wise;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      frame_clk_half_rate <= 1'b0;
    end else begin
      frame_clk_half_rate <= next_half_rate;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      byte_wise_active <= 1'b0;
    end else begin
      byte_wise_active <= next_byte_wise;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bit_wise_active <= 1'b0;
    end else begin
      bit_wise_active <= next_bit_wise;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      serial_mode_active <= 1'b0;
    end else begin
      serial_mode_active <= serial_mode;
    end
  end

  // Parallel control flags.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      parallel_deskew <= 1'b0;
    end else begin
      parallel_deskew <= next_deskew;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      parallel_sync <= 1'b0;
    end else begin
      parallel_sync <= next_sync;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      parallel_power_down <= 1'b0;
    end else begin
      parallel_power_down <= next_pdown;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      parallel_gain_ref_sel <= 1'b0;
    end else begin
      parallel_gain_ref_sel <= next_gain_ref;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= write_soft;
    end
  end

endmodule

// ---- dv/lotc_asserts.sv ----
/*
  Checker for the termination and word-mode register and the control pins.
  It assumes it is bound to lotc_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module lotc_asserts (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       reset_pin,
  input wire logic       serial_clk_pin,
  input wire logic       serial_port_data_pin,
  input wire logic       serial_port_enable_pin,
  input wire logic       two_wire_select,
  input wire logic       bit_wise_select,
  input wire logic [4:0] data_term_enable,
  input wire logic [1:0] word_mode_field,
  input wire logic       word_wise_active,
  input wire logic       frame_clk_half_rate,
  input wire logic       byte_wise_active,
  input wire logic       bit_wise_active,
  input wire logic       serial_mode_active,
  input wire logic       parallel_deskew,
  input wire logic       parallel_sync,
  input wire logic       parallel_power_down,
  input wire logic       parallel_gain_ref_sel,
  input wire logic       soft_reset_pulse
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_calm;
    !$past(srst) && $stable(two_wire_select) && $stable(bit_wise_select) && $stable(word_mode_field);
  endsequence
  sequence s_par;
    (reset_pin && $stable({serial_clk_pin, serial_port_data_pin, serial_port_enable_pin}))[*5];
  endsequence
  property p_word; s_calm |-> word_wise_active == (two_wire_select && word_mode_field == 2'h3); endproperty
  a_word: assert property (p_word) else $error("word mode decode wrong");
  property p_half; s_calm |-> frame_clk_half_rate == (two_wire_select && word_mode_field == 2'h3); endproperty
  a_half: assert property (p_half) else $error("frame rate wrong");
  property p_bit; s_calm |-> bit_wise_active == (two_wire_select && !word_wise_active && bit_wise_select)
    && byte_wise_active == (two_wire_select && !word_wise_active && !bit_wise_select); endproperty
  a_bit: assert property (p_bit) else $error("byte or bit select wrong");
  property p_srst; $past(srst) |-> data_term_enable == 5'h00 && word_mode_field == 2'h0; endproperty
  a_srst: assert property (p_srst) else $error("register not cleared by srst");
  property p_soft; soft_reset_pulse |-> ##[0:2] (data_term_enable == 5'h00 && word_mode_field == 2'h0); endproperty
  a_soft: assert property (p_soft) else $error("soft reset did not clear");
  property p_pin; reset_pin[*6] |-> data_term_enable == 5'h00 && word_mode_field == 2'h0 && !serial_mode_active;
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin did not clear");
  property p_par; s_par |-> parallel_deskew == ({serial_clk_pin, serial_port_data_pin} == 2'h1)
    && parallel_sync == ({serial_clk_pin, serial_port_data_pin} == 2'h2)
    && parallel_power_down == (serial_clk_pin && serial_port_data_pin); endproperty
  a_par: assert property (p_par) else $error("parallel mode decode wrong");
  property p_gain; s_par |-> parallel_gain_ref_sel == serial_port_enable_pin; endproperty
  a_gain: assert property (p_gain) else $error("gain select wrong");
  property p_ser; (!reset_pin)[*5] |-> serial_mode_active && !(parallel_deskew || parallel_sync
    || parallel_power_down || parallel_gain_ref_sel); endproperty
  a_ser: assert property (p_ser) else $error("serial mode pins misused");
endmodule
bind lotc_top lotc_asserts u_chk (.*);

// ---- dv/lotc_host.sv ----
/*
  Host model that drives the three control pins, as frames or as levels.
  It assumes its tasks are called at the falling edge of core_clk.
*/
`timescale 1ns/1ps
module lotc_host (
  input  wire logic core_clk,
  output logic      clk_pin,
  output logic      dat_pin,
  output logic      en_n_pin
);
  initial begin
    clk_pin = 1'b0;
    dat_pin = 1'b0;
    en_n_pin = 1'b1;
  end
  // Idle pins sit at their pull levels, so stale data never lingers.
  task automatic wr(input logic [4:0] a, input logic [10:0] d);
    logic [15:0] f;
    f = {a, d[10:9], 4'h0, d[4:0]};
    en_n_pin = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      dat_pin = f[i];
      repeat (3) @(negedge core_clk);
      clk_pin = 1'b1;
      repeat (3) @(negedge core_clk);
      clk_pin = 1'b0;
    end
    en_n_pin = 1'b1;
    dat_pin = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic par(input logic [2:0] p);
    {clk_pin, dat_pin, en_n_pin} = p;
  endtask
endmodule

// ---- dv/tb.sv ----
/*
  Testbench for lotc_top: serial writes through the host model, parallel pin levels.
  It assumes the host model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
module tb;
  logic       core_clk, srst, reset_pin, two_wire_select, bit_wise_select;
  wire logic  clk_pin, dat_pin, en_n_pin;
  logic [4:0] dte;
  logic [1:0] wmf;
  logic       ww, hr, bw, btw, sm, pd, ps, ppd, pg, srp;
  int         error_cnt, n_tests, n_soft;
  logic [4:0] tv [7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h05, 5'h1F};
  lotc_host host (.core_clk(core_clk), .clk_pin(clk_pin), .dat_pin(dat_pin), .en_n_pin(en_n_pin));
  lotc_top dut (.core_clk(core_clk), .srst(srst), .reset_pin(reset_pin), .serial_clk_pin(clk_pin),
    .serial_port_data_pin(dat_pin), .serial_port_enable_pin(en_n_pin), .two_wire_select(two_wire_select),
    .bit_wise_select(bit_wise_select), .data_term_enable(dte), .word_mode_field(wmf), .word_wise_active(ww),
    .frame_clk_half_rate(hr), .byte_wise_active(bw), .bit_wise_active(btw), .serial_mode_active(sm),
    .parallel_deskew(pd), .parallel_sync(ps), .parallel_power_down(ppd), .parallel_gain_ref_sel(pg),
    .soft_reset_pulse(srp));
  always @(negedge core_clk) begin
    if (srp === 1'b1) n_soft++;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    final_report();
  end
  initial begin
    {srst, reset_pin, two_wire_select, bit_wise_select} = 4'h A;
    error_cnt = 0;
    n_tests = 0;
    n_soft = 0;
    cyc(12);
    srst = 1'b0;
    cyc(4);
    foreach (tv[i]) begin
      host.wr(5'h11, {6'h00, tv[i]});
      chk("term", 11'(tv[i]), 11'(dte));
      chk("byte", 11'h1, 11'(bw));
    end
    $display("termination test done");
    host.wr(5'h11, 11'h613);
    chk("wmode", 11'h3, 11'(wmf));
    chk("word", 11'h3, 11'({ww, hr}));
    two_wire_select = 1'b0;
    cyc(3);
    chk("one wire", 11'h0, 11'({ww, hr, bw, btw}));
    two_wire_select = 1'b1;
    bit_wise_select = 1'b1;
    host.wr(5'h11, 11'h013);
    chk("bit", 11'h1, 11'({ww, hr, bw, btw}));
    host.wr(5'h12, 11'h601);
    chk("unmapped", 11'h13, 11'(dte));
    $display("word mode test done");
    host.wr(5'h00, 11'h002);
    chk("soft", 11'h0, 11'({wmf, dte}));
    chk("soft pulse", 11'h1, 11'(n_soft));
    host.wr(5'h11, 11'h61F);
    chk("pre srst", 11'h7F, 11'({wmf, dte}));
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(2);
    chk("srst", 11'h0, 11'({wmf, dte}));
    host.wr(5'h11, 11'h604);
    chk("pre pin", 11'h64, 11'({wmf, dte}));
    reset_pin = 1'b1;
    cyc(6);
    chk("pin clear", 11'h0, 11'({wmf, dte, sm}));
    $display("reset test done");
    for (int p = 0; p < 8; p++) begin
      host.par(3'(p));
      cyc(5);
      chk("par", 11'({p[2] & p[1], p[2] & ~p[1], ~p[2] & p[1], p[0]}), 11'({ppd, ps, pd, pg}));
    end
    host.par(3'h1);
    reset_pin = 1'b0;
    cyc(5);
    chk("serial", 11'h1, 11'({pd, ps, ppd, pg, sm}));
    host.wr(5'h11, 11'h008);
    chk("rewrite", 11'h08, 11'(dte));
    $display("pin role test done");
    final_report();
  end
endmodule
